// ### hdl/llcpd_supervisor.sv
`timescale 1ns/1ps
// Functional notes
// - Decode timing-set level into seventeen banded options
// - Second measure sets frequency; difference sets integrator
// - Measure high-to-low dead time, reuse it after
// - No copy after missed slew or zero-current
// - Polarity comparator also ends dead time when allowed
// - Below brown-out stop: brown-out state, no switching
// - Hysteresis sink enabled only in brown-out state
// - Brown-in starts soft start at once
// - Enabled input overvoltage stops switching, enters fault
// - After idle, restart if input overvoltage cleared
// - Protection overvoltage must persist 40 us to trip
// - Below temperature threshold enters overtemperature fault
// - Overtemperature: wait 1 s, retest, restart if high
// - Overtemperature detection off during burst operation
// - Clamp current on while feedback below clamp level
// - Fault idle lasts 1 s before retry
module llcpd_supervisor
  import llcpd_pkg::*;
#(
  parameter int FAULT_IDLE_CYCLES = FAULT_IDLE_CYC
)(
  input  wire logic        sys_clk,
  input  wire logic        rst,
  input  wire logic        measureDone,
  input  wire logic [11:0] timingSetFirstMeasure,
  input  wire logic [11:0] timingSetSecondMeasure,
  input  wire logic        brownoutStopBelow,
  input  wire logic        brownInAbove,
  input  wire logic        inputOvAbove,
  input  wire logic        inputOvEnable,
  input  wire logic        protAboveOvThreshold,
  input  wire logic        protBelowTempThreshold,
  input  wire logic        feedbackBelowClamp,
  input  wire logic        burstMode,
  input  wire logic        zcsPrevention,
  input  wire logic        slowSlew,
  input  wire logic        highSideOff,
  input  wire logic        lowSideOff,
  input  wire logic        slewDone,
  input  wire logic        currentPolarity,
  input  wire logic        zeroCurrentEvent,
  output      logic        switchEnable,
  output      logic        softStartReq,
  output      logic        faultActive,
  output      logic [1:0]  faultCause,
  output      logic        brownoutHysteresisSinkEn,
  output      logic        feedbackClampCurrentEn,
  output      logic        otpDetectEn,
  output      logic        deadTimeEnd,
  output      logic [4:0]  measuredDeadTime,
  output      logic        tsetValid,
  output      logic        tsetError,
  output      logic [4:0]  tsetMinFreqOption,
  output      logic [4:0]  tsetIntegratorOption,
  output      logic        tsetDeadTimeShort
);

  // ****************************************************************
  // State record
  // ****************************************************************
  typedef struct packed {
    logic [SYNC_N-1:0] sync1;
    logic [SYNC_N-1:0] sync2;
    llcpd_state_t      state;
    logic [24:0]       idleCnt;
    logic [9:0]        ovCnt;
    logic [9:0]        ovRun;
    logic [1:0]        cause;
    logic              inHl;
    logic              inLh;
    logic              copyOk;
    logic              slewSeen;
    logic              zcsPrev;
    logic              zcsThis;
    logic [4:0]        dtCnt;
    logic [4:0]        dtMeas;
    logic              dtEnd;
    logic              softStart;
    logic              switchEn;
    logic              fault;
    logic              sinkEn;
    logic              clampEn;
    logic              otpEn;
    logic              tValid;
    logic              tErr;
    logic [4:0]        tFreq;
    logic [4:0]        tInteg;
    logic              tShort;
  } llcpd_regs_t;

  llcpd_regs_t st_reg;
  llcpd_regs_t st_next;

  logic        secHit;
  logic [4:0]  secOpt;
  logic        difHit;
  logic [4:0]  difOpt;
  logic [11:0] diffMv;
  logic [4:0]  dtLimit;
  logic        ipolAllowed;
  logic        boS;
  logic        biS;
  logic        ivS;
  logic        povS;
  logic        potS;
  logic        slS;
  logic        ipS;

  // ****************************************************************
  // Timing-set decoders
  // ****************************************************************
  assign diffMv = (timingSetFirstMeasure >= timingSetSecondMeasure) ?
                  timingSetFirstMeasure - timingSetSecondMeasure : 12'h000;

  llcpd_timing_set_pin_decode uSecond (
    .levelMv (timingSetSecondMeasure),
    .hit     (secHit),
    .option  (secOpt)
  );

  llcpd_timing_set_pin_decode uDiff (
    .levelMv (diffMv),
    .hit     (difHit),
    .option  (difOpt)
  );

  assign boS  = st_reg.sync2[SY_BO_STOP];
  assign biS  = st_reg.sync2[SY_BO_IN];
  assign ivS  = st_reg.sync2[SY_IN_OV] & inputOvEnable;
  assign povS = st_reg.sync2[SY_PROT_OV];
  assign potS = st_reg.sync2[SY_PROT_OT];
  assign slS  = st_reg.sync2[SY_SLEW];
  assign ipS  = st_reg.sync2[SY_IPOL];
  assign dtLimit     = st_reg.tShort ? DT_SHORT_CYC : DT_LONG_CYC;
  assign ipolAllowed = burstMode | zcsPrevention | slowSlew;

  // ****************************************************************
  // Next state
  // ****************************************************************
  always_comb begin
    st_next           = st_reg;
    st_next.sync1     = {feedbackBelowClamp, zeroCurrentEvent, currentPolarity, slewDone,
                         protBelowTempThreshold, protAboveOvThreshold, inputOvAbove,
                         brownInAbove, brownoutStopBelow};
    st_next.sync2     = st_reg.sync1;
    st_next.softStart = 1'b0;
    st_next.dtEnd     = 1'b0;

    if (measureDone) begin
      st_next.tValid = secHit & difHit;
      st_next.tErr   = ~(secHit & difHit) | (timingSetSecondMeasure < TIMING_SET_PIN_FLOOR_MV);
      st_next.tFreq  = secOpt;
      st_next.tInteg = difOpt;
      st_next.tShort = secHit & (secOpt >= TIMING_SET_PIN_SHORT_MIN);
    end

    // Filter on the overvoltage level; any dip restarts the 40 us window
    if (povS && (st_reg.state == ST_RUN || st_reg.state == ST_START)) begin
      st_next.ovCnt = st_reg.ovCnt + 10'h001;
    end else begin
      st_next.ovCnt = 10'h000;
    end
    st_next.ovRun = povS ? st_reg.ovRun + 10'(~&st_reg.ovRun) : 10'h000;

    case (st_reg.state)
      ST_BROWN: begin
        if (biS) begin
          st_next.state     = ST_START;
          st_next.softStart = 1'b1;
        end
      end
      ST_START, ST_RUN: begin
        st_next.state = ST_RUN;
        if (boS) begin
          st_next.state = ST_BROWN;
        end else if (ivS) begin
          st_next.state = ST_IDLE;
          st_next.cause = CAUSE_IN_OV;
        end else if (povS && 32'(st_reg.ovCnt) == OVP_FILTER_CYC - 1) begin
          st_next.state = ST_IDLE;
          st_next.cause = CAUSE_PROT_OV;
        end else if (potS && st_reg.otpEn) begin
          st_next.state = ST_IDLE;
          st_next.cause = CAUSE_PROT_OT;
        end
        st_next.idleCnt = 25'h0000000;
      end
      ST_IDLE: begin
        st_next.idleCnt = st_reg.idleCnt + 25'h0000001;
        if (32'(st_reg.idleCnt) == FAULT_IDLE_CYCLES - 1) begin
          st_next.idleCnt = 25'h0000000;
          if (st_reg.cause == CAUSE_IN_OV) begin
            st_next.state = ivS ? ST_HOLD : ST_START;
          end else if (st_reg.cause == CAUSE_PROT_OT) begin
            // A cool pin never goes high, so this retests every second
            st_next.state = povS ? ST_START : ST_IDLE;
          end else begin
            st_next.state = ST_START;
          end
          st_next.softStart = (st_next.state == ST_START);
        end
      end
      ST_HOLD: begin
        if (!ivS) begin
          st_next.state     = ST_START;
          st_next.softStart = 1'b1;
        end
      end
      default: begin
        st_next.state = ST_BROWN;
      end
    endcase

    if (st_next.state == ST_START) begin
      st_next.cause = CAUSE_NONE;
    end
    st_next.switchEn = (st_next.state == ST_START) || (st_next.state == ST_RUN);
    st_next.fault    = (st_next.state == ST_IDLE) || (st_next.state == ST_HOLD);
    st_next.sinkEn   = (st_next.state == ST_BROWN);
    st_next.clampEn  = st_reg.sync2[SY_FB_CLAMP];
    st_next.otpEn    = ~burstMode;

    // ****************************************************************
    // Adaptive dead time
    // ****************************************************************
    if (st_reg.sync2[SY_ZCS]) begin
      st_next.zcsThis = 1'b1;
    end
    if (!st_reg.switchEn) begin
      st_next.inHl = 1'b0;
      st_next.inLh = 1'b0;
    end else if (highSideOff) begin
      st_next.inHl     = 1'b1;
      st_next.inLh     = 1'b0;
      st_next.dtCnt    = 5'h00;
      st_next.slewSeen = 1'b0;
      st_next.zcsPrev  = st_reg.zcsThis | st_reg.sync2[SY_ZCS];
      st_next.zcsThis  = 1'b0;
    end else if (lowSideOff) begin
      st_next.inLh   = 1'b1;
      st_next.inHl   = 1'b0;
      st_next.dtCnt  = 5'h00;
      st_next.copyOk = st_reg.slewSeen & ~st_reg.zcsPrev;
    end else if (st_reg.inHl) begin
      st_next.dtCnt = st_reg.dtCnt + 5'h01;
      if (slS || (ipolAllowed && !ipS) || st_next.dtCnt >= dtLimit) begin
        st_next.inHl     = 1'b0;
        st_next.dtEnd    = 1'b1;
        st_next.dtMeas   = st_next.dtCnt;
        st_next.slewSeen = slS;
      end
    end else if (st_reg.inLh) begin
      st_next.dtCnt = st_reg.dtCnt + 5'h01;
      if (st_reg.copyOk ? (st_next.dtCnt >= st_reg.dtMeas) : ipS) begin
        st_next.inLh  = 1'b0;
        st_next.dtEnd = 1'b1;
      end else if (st_next.dtCnt >= dtLimit) begin
        st_next.inLh  = 1'b0;
        st_next.dtEnd = 1'b1;
      end
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      st_reg       <= '0;
      st_reg.state <= ST_BROWN;
      st_reg.otpEn <= 1'b1;
      st_reg.sinkEn <= 1'b1;
    end else begin
      st_reg <= st_next;
    end
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  assign switchEnable             = st_reg.switchEn;
  assign softStartReq             = st_reg.softStart;
  assign faultActive              = st_reg.fault;
  assign faultCause               = st_reg.cause;
  assign brownoutHysteresisSinkEn = st_reg.sinkEn;
  assign feedbackClampCurrentEn   = st_reg.clampEn;
  assign otpDetectEn              = st_reg.otpEn;
  assign deadTimeEnd              = st_reg.dtEnd;
  assign measuredDeadTime         = st_reg.dtMeas;
  assign tsetValid                = st_reg.tValid;
  assign tsetError                = st_reg.tErr;
  assign tsetMinFreqOption        = st_reg.tFreq;
  assign tsetIntegratorOption     = st_reg.tInteg;
  assign tsetDeadTimeShort        = st_reg.tShort;

  // ****************************************************************
  // Checks
  // ****************************************************************
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);

  a_brown_stop: assert property (st_reg.state == ST_RUN && boS |=>
    st_reg.state == ST_BROWN ##1 !switchEnable) else $error("brown-out did not stop");
  a_sink_state: assert property (brownoutHysteresisSinkEn ==
    (st_reg.state == ST_BROWN)) else $error("sink mismatch");
  a_brownin_fast: assert property (st_reg.state == ST_BROWN && biS |=>
    softStartReq && switchEnable) else $error("brown-in not immediate");
  a_inov_trip: assert property (st_reg.state == ST_RUN && ivS && !boS |=>
    faultActive && faultCause == CAUSE_IN_OV) else $error("input ov missed");
  a_ovp_filter: assert property ($past(st_reg.state) == ST_RUN &&
    st_reg.state == ST_IDLE && faultCause == CAUSE_PROT_OV |-> st_reg.ovRun >= 10'(OVP_FILTER_CYC))
    else $error("ovp tripped early");
  a_fault_quiet: assert property (faultActive |-> !switchEnable)
    else $error("switching in fault");
  a_idle_time: assert property ($past(st_reg.state) == ST_IDLE &&
    st_reg.state == ST_START |-> 32'($past(st_reg.idleCnt)) == FAULT_IDLE_CYCLES - 1)
    else $error("idle time wrong");
  a_otp_burst: assert property (burstMode |=> !otpDetectEn)
    else $error("otp active in burst");
  a_clamp_follow: assert property (st_reg.sync2[SY_FB_CLAMP] |=>
    feedbackClampCurrentEn) else $error("clamp not enabled");
  a_timing_set_pin_short: assert property (measureDone && secHit && secOpt >= TIMING_SET_PIN_SHORT_MIN |=>
    tsetDeadTimeShort) else $error("short dead time missed");
  a_dt_copy: assert property (deadTimeEnd && $past(st_reg.inLh) && $past(st_reg.copyOk)
    |-> st_reg.dtCnt >= st_reg.dtMeas) else $error("copied dead time wrong");
  a_dt_limit: assert property (st_reg.inHl |-> st_reg.dtCnt < dtLimit)
    else $error("dead time over limit");

  c_brown_cycle: cover property (st_reg.state == ST_BROWN ##1 st_reg.state == ST_START);
  c_ovp_fault: cover property (faultActive && faultCause == CAUSE_PROT_OV);
  c_dt_copy: cover property (deadTimeEnd && $past(st_reg.inLh) && $past(st_reg.copyOk));
  c_hold: cover property (st_reg.state == ST_HOLD);

endmodule

// ### hdl/llcpd_pkg.sv
package llcpd_pkg;

  // ****************************************************************
  // Clock and timing
  // ****************************************************************
  localparam int CLK_FREQ_HZ    = 20_000_000;
  localparam int CLK_PER_US     = CLK_FREQ_HZ / 1_000_000;
  localparam int OVP_FILTER_US  = 40;
  localparam int OVP_FILTER_CYC = OVP_FILTER_US * CLK_PER_US;
  localparam int FAULT_IDLE_MS  = 1000;
  localparam int FAULT_IDLE_CYC = FAULT_IDLE_MS * (CLK_FREQ_HZ / 1000);
  localparam int DT_LONG_NS     = 1000;
  localparam int DT_SHORT_NS    = 500;
  // Longest times round down to whole cycles
  localparam logic [4:0] DT_LONG_CYC  = 5'((DT_LONG_NS * CLK_PER_US) / 1000);
  localparam logic [4:0] DT_SHORT_CYC = 5'((DT_SHORT_NS * CLK_PER_US) / 1000);

  // ****************************************************************
  // Timing-set decode
  // ****************************************************************
  localparam int         TIMING_SET_PIN_OPTIONS   = 17;
  localparam logic [4:0] TIMING_SET_PIN_SHORT_MIN = 5'h0e;
  localparam logic [11:0] TIMING_SET_PIN_BAND_MV  = 12'h030;
  localparam logic [11:0] TIMING_SET_PIN_FLOOR_MV = 12'h188;
  // Nominal levels in mV, entry 0 is option 1
  localparam logic [16:0][11:0] TIMING_SET_PIN_NOM_MV = {
    12'h8f7, 12'h878, 12'h7f9, 12'h77a, 12'h6fb, 12'h67c, 12'h5fd, 12'h588,
    12'h513, 12'h49e, 12'h432, 12'h3c7, 12'h352, 12'h2e6, 12'h284, 12'h223,
    12'h1c2};

  // ****************************************************************
  // Synchronised comparator inputs
  // ****************************************************************
  localparam int SYNC_N      = 9;
  localparam int SY_BO_STOP  = 0;
  localparam int SY_BO_IN    = 1;
  localparam int SY_IN_OV    = 2;
  localparam int SY_PROT_OV  = 3;
  localparam int SY_PROT_OT  = 4;
  localparam int SY_SLEW     = 5;
  localparam int SY_IPOL     = 6;
  localparam int SY_ZCS      = 7;
  localparam int SY_FB_CLAMP = 8;

  // ****************************************************************
  // States and fault causes
  // ****************************************************************
  typedef enum logic [2:0] {
    ST_BROWN = 3'h0,
    ST_START = 3'h1,
    ST_RUN   = 3'h3,
    ST_IDLE  = 3'h2,
    ST_HOLD  = 3'h6
  } llcpd_state_t;

  localparam logic [1:0] CAUSE_NONE    = 2'h0;
  localparam logic [1:0] CAUSE_IN_OV   = 2'h1;
  localparam logic [1:0] CAUSE_PROT_OV = 2'h2;
  localparam logic [1:0] CAUSE_PROT_OT = 2'h3;

endpackage

// ### hdl/llcpd_timing_set_pin_decode.sv
`timescale 1ns/1ps
module llcpd_timing_set_pin_decode
  import llcpd_pkg::*;
(
  input  wire logic [11:0] levelMv,
  output      logic        hit,
  output      logic [4:0]  option
);

  // ****************************************************************
  // Band match per option
  // ****************************************************************
  logic [TIMING_SET_PIN_OPTIONS-1:0] match;

  genvar g;
  generate
    for (g = 0; g < TIMING_SET_PIN_OPTIONS; g++) begin : gBand
      assign match[g] = (levelMv >= TIMING_SET_PIN_NOM_MV[g] - TIMING_SET_PIN_BAND_MV) &&
                        (levelMv <= TIMING_SET_PIN_NOM_MV[g] + TIMING_SET_PIN_BAND_MV);
    end
  endgenerate

  // Bands never overlap, so at most one bit is set
  always_comb begin
    hit    = 1'b0;
    option = 5'h00;
    for (int i = 0; i < TIMING_SET_PIN_OPTIONS; i++) begin
      if (match[i]) begin
        hit    = 1'b1;
        option = 5'(i + 1);
      end
    end
  end

endmodule

// ### testbench/llcpd_stage_model.sv
`timescale 1ns/1ps
// ****
// Comparators and slew/polarity sense of the power stage
// ****
module llcpd_stage_model #(
  parameter int BO_STOP_MV  = 1000,
  parameter int BO_IN_MV    = 1100,
  parameter int IN_OV_MV    = 3000,
  parameter int PROT_OV_MV  = 2500,
  parameter int PROT_OT_MV  = 500,
  parameter int FB_CLAMP_MV = 800
)(
  input  wire logic        sys_clk,
  input  wire logic [11:0] senseMv,
  input  wire logic [11:0] protMv,
  input  wire logic [11:0] fbMv,
  input  wire logic [4:0]  slewDelay,
  input  wire logic [4:0]  polDelay,
  input  wire logic        highSideOff,
  input  wire logic        lowSideOff,
  output      logic        brownoutStopBelow,
  output      logic        brownInAbove,
  output      logic        inputOvAbove,
  output      logic        protAboveOvThreshold,
  output      logic        protBelowTempThreshold,
  output      logic        feedbackBelowClamp,
  output      logic        slewDone,
  output      logic        currentPolarity
);
  logic [5:0] sinceOff = 6'h3f;
  logic       lastHigh = 1'b0;

  always @(posedge sys_clk) begin
    if (highSideOff || lowSideOff) begin
      sinceOff <= 6'h00;
      lastHigh <= highSideOff;
    end else if (sinceOff != 6'h3f) begin
      sinceOff <= sinceOff + 6'h01;
    end
  end

  assign brownoutStopBelow      = senseMv < 12'(BO_STOP_MV);
  assign brownInAbove           = senseMv > 12'(BO_IN_MV);
  assign inputOvAbove           = senseMv > 12'(IN_OV_MV);
  assign protAboveOvThreshold   = protMv > 12'(PROT_OV_MV);
  assign protBelowTempThreshold = protMv < 12'(PROT_OT_MV);
  assign feedbackBelowClamp     = fbMv < 12'(FB_CLAMP_MV);
  // Slew flag drops after two cycles, so a stale edge never lingers
  assign slewDone = (slewDelay != 5'h00) && (sinceOff >= {1'b0, slewDelay})
                    && (sinceOff < {1'b0, slewDelay} + 6'h02);
  // Current keeps its sign until the tank swings round
  assign currentPolarity = (sinceOff < {1'b0, polDelay}) ? lastHigh : !lastHigh;
endmodule

// ### testbench/llc_protection_deadtime_logic_tb.sv
`timescale 1ns/1ps
module llc_protection_deadtime_logic_tb;
  import llcpd_pkg::*;
  logic sys_clk = 1'b0, rst = 1'b1, measureDone = 1'b0, inputOvEnable = 1'b0;
  logic burstMode = 1'b0, zcsPrevention = 1'b0, slowSlew = 1'b0, zeroCurrentEvent = 1'b0;
  logic highSideOff = 1'b0, lowSideOff = 1'b0, mdPend = 1'b0;
  logic [11:0] timingSetFirstMeasure = 12'h000, timingSetSecondMeasure = 12'h000;
  logic [11:0] senseMv = 12'h000, protMv = 12'h5dc, fbMv = 12'h3e8;
  logic [4:0]  slewDelay = 5'h00, polDelay = 5'h1f, measuredDeadTime;
  logic [4:0]  tsetMinFreqOption, tsetIntegratorOption;
  logic [1:0]  faultCause;
  logic brownoutStopBelow, brownInAbove, inputOvAbove, protAboveOvThreshold;
  logic protBelowTempThreshold, feedbackBelowClamp, slewDone, currentPolarity;
  logic switchEnable, softStartReq, faultActive, brownoutHysteresisSinkEn;
  logic feedbackClampCurrentEn, otpDetectEn, deadTimeEnd, tsetValid, tsetError;
  logic tsetDeadTimeShort;
  logic [25:0] notes[$];
  int failures = 0, checks = 0, seed = 27739, n, m, nLong;

  always #25 sys_clk = ~sys_clk;

  llcpd_supervisor #(.FAULT_IDLE_CYCLES(50)) dut (.sys_clk, .rst, .measureDone,
    .timingSetFirstMeasure, .timingSetSecondMeasure, .brownoutStopBelow, .brownInAbove,
    .inputOvAbove, .inputOvEnable, .protAboveOvThreshold, .protBelowTempThreshold,
    .feedbackBelowClamp, .burstMode, .zcsPrevention, .slowSlew, .highSideOff, .lowSideOff,
    .slewDone, .currentPolarity, .zeroCurrentEvent, .switchEnable, .softStartReq,
    .faultActive, .faultCause, .brownoutHysteresisSinkEn, .feedbackClampCurrentEn,
    .otpDetectEn, .deadTimeEnd, .measuredDeadTime, .tsetValid, .tsetError,
    .tsetMinFreqOption, .tsetIntegratorOption, .tsetDeadTimeShort);

  llcpd_stage_model model (.sys_clk, .senseMv, .protMv, .fbMv, .slewDelay, .polDelay,
    .highSideOff, .lowSideOff, .brownoutStopBelow, .brownInAbove, .inputOvAbove,
    .protAboveOvThreshold, .protBelowTempThreshold, .feedbackBelowClamp, .slewDone,
    .currentPolarity);

  // ****
  // Shared tasks
  // ****
  task automatic tally_and_finish();
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
    checks++;
    if (seen !== exp) begin
      failures++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask

  function automatic logic pick(input int s);
    case (s)
      0: return switchEnable;
      1: return faultActive;
      2: return brownoutHysteresisSinkEn;
      3: return deadTimeEnd;
      default: return softStartReq;
    endcase
  endfunction

  // Counts falling edges until the chosen output reaches v; a spent bound ends the run
  task automatic waitFor(input int s, input logic v, input int lim, output int cnt);
    cnt = 0;
    do begin
      @(negedge sys_clk);
      cnt++;
    end while (pick(s) !== v && cnt < lim);
    chk($sformatf("wait %0d", s), 16'(pick(s)), 16'(v));
    if (pick(s) !== v) tally_and_finish();
  endtask

  task automatic cycles(input int k);
    repeat (k) @(posedge sys_clk);
  endtask

  task automatic timing_set_pin(input int k, input int j, input int off, input logic err);
    logic [12:0] e;
    e = {1'b1, 1'b0, 5'(k + 1), 5'(j + 1), 1'(k >= 13)};
    @(posedge sys_clk);
    measureDone <= 1'b1;
    timingSetSecondMeasure <= 12'(int'(TIMING_SET_PIN_NOM_MV[k]) + off);
    timingSetFirstMeasure <= 12'(int'(TIMING_SET_PIN_NOM_MV[k]) + off + int'(TIMING_SET_PIN_NOM_MV[j]));
    notes.push_back(err ? {13'h0800, 13'h0800} : {13'h1fff, e});
    @(posedge sys_clk);
    measureDone <= 1'b0;
  endtask

  task automatic dtime(input logic hs, output int cnt);
    @(posedge sys_clk);
    highSideOff <= hs;
    lowSideOff <= !hs;
    @(posedge sys_clk);
    highSideOff <= 1'b0;
    lowSideOff <= 1'b0;
    waitFor(3, 1'b1, 40, cnt);
    cycles(4);
  endtask

  // Results of each timing-set measure appear one cycle after it is taken
  always @(negedge sys_clk) begin
    logic [25:0] nt;
    if (mdPend) begin
      nt = notes.pop_front();
      chk("timing_set_pin", 16'({tsetValid, tsetError, tsetMinFreqOption, tsetIntegratorOption,
          tsetDeadTimeShort} & nt[25:13]), 16'(nt[12:0] & nt[25:13]));
    end
    mdPend = measureDone;
  end

  // ****
  // Main sequence
  // ****
  initial begin
    cycles(6);
    rst <= 1'b0;
    @(negedge sys_clk);
    chk("otpEn", 16'(otpDetectEn), 16'h1);
    chk("switch", 16'(switchEnable), 16'h0);
    waitFor(2, 1'b1, 3, n);
    $display("test reset done");
    // Divider kept above the floor except in the last error case
    for (int k = 0; k < 17; k++) timing_set_pin(k, 16 - k, $random(seed) % 49, 1'b0);
    timing_set_pin(0, 3, 48, 1'b0);
    timing_set_pin(16, 0, -48, 1'b0);
    timing_set_pin(5, 2, -49, 1'b1);
    timing_set_pin(0, 1, -194, 1'b1);
    timing_set_pin(0, 0, 0, 1'b0);
    cycles(3);
    $display("test timing set done");
    senseMv <= 12'h7d0;
    waitFor(4, 1'b1, 6, n);
    chk("switch", 16'(switchEnable), 16'h1);
    chk("sink", 16'(brownoutHysteresisSinkEn), 16'h0);
    $display("test brown-in done");
    repeat (8) begin
      @(posedge sys_clk);
      fbMv <= 12'(12'h190 + ($random(seed) & 32'h3ff));
      cycles(4);
      @(negedge sys_clk);
      chk("clamp", 16'(feedbackClampCurrentEn), 16'(fbMv < 12'h320));
    end
    $display("test clamp done");
    @(posedge sys_clk);
    slewDelay <= 5'h04;
    dtime(1'b1, n);
    dtime(1'b0, m);
    chk("copy", 16'(m), 16'(n));
    chk("measured", 16'(measuredDeadTime != 5'h00), 16'h1);
    slewDelay <= 5'h00;
    polDelay <= 5'h06;
    dtime(1'b1, nLong);
    dtime(1'b0, m);
    chk("noSlew", 16'(m < nLong), 16'h1);
    for (int i = 0; i < 3; i++) begin
      {burstMode, zcsPrevention, slowSlew} <= 3'(1 << i);
      dtime(1'b1, m);
      chk("polEnd", 16'(m < nLong), 16'h1);
    end
    {burstMode, zcsPrevention, slowSlew} <= 3'h0;
    slewDelay <= 5'h04;
    polDelay <= 5'h0c;
    zeroCurrentEvent <= 1'b1;
    cycles(3);
    zeroCurrentEvent <= 1'b0;
    dtime(1'b1, n);
    dtime(1'b0, m);
    chk("zcsNoCopy", 16'(m != n), 16'h1);
    timing_set_pin(13, 0, 0, 1'b0);
    slewDelay <= 5'h00;
    polDelay <= 5'h1f;
    dtime(1'b1, m);
    chk("shortLimit", 16'(nLong - m), 16'h000a);
    timing_set_pin(0, 0, 0, 1'b0);
    $display("test dead time done");
    burstMode <= 1'b1;
    protMv <= 12'h12c;
    cycles(20);
    @(negedge sys_clk);
    chk("otpOff", 16'({otpDetectEn, faultActive}), 16'h0);
    protMv <= 12'h5dc;
    cycles(4);
    burstMode <= 1'b0;
    cycles(3);
    @(negedge sys_clk);
    chk("otpOn", 16'(otpDetectEn), 16'h1);
    $display("test burst done");
    @(posedge sys_clk);
    protMv <= 12'ha28;
    cycles(700);
    protMv <= 12'h5dc;
    cycles(6);
    @(negedge sys_clk);
    chk("ovpGlitch", 16'(faultActive), 16'h0);
    @(posedge sys_clk);
    protMv <= 12'ha28;
    waitFor(1, 1'b1, 900, n);
    chk("ovpTime", 16'(n >= 798 && n <= 806), 16'h1);
    chk("ovpCause", 16'({faultCause, switchEnable}), 16'({CAUSE_PROT_OV, 1'b0}));
    @(posedge sys_clk);
    protMv <= 12'h5dc;
    waitFor(1, 1'b0, 70, n);
    chk("idle", 16'(n >= 47 && n <= 56), 16'h1);
    $display("test output overvoltage done");
    cycles(4);
    senseMv <= 12'hc80;
    cycles(20);
    @(negedge sys_clk);
    chk("inOvOff", 16'(faultActive), 16'h0);
    @(posedge sys_clk);
    inputOvEnable <= 1'b1;
    waitFor(1, 1'b1, 6, n);
    chk("inOvCause", 16'({faultCause, switchEnable}), 16'({CAUSE_IN_OV, 1'b0}));
    cycles(100);
    @(negedge sys_clk);
    chk("inOvHold", 16'(faultActive), 16'h1);
    @(posedge sys_clk);
    senseMv <= 12'h7d0;
    waitFor(1, 1'b0, 8, n);
    $display("test input overvoltage done");
    cycles(4);
    protMv <= 12'h12c;
    waitFor(1, 1'b1, 6, n);
    chk("otCause", 16'(faultCause), 16'(CAUSE_PROT_OT));
    @(posedge sys_clk);
    protMv <= 12'ha28;
    waitFor(1, 1'b0, 70, n);
    @(posedge sys_clk);
    protMv <= 12'h5dc;
    chk("otWait", 16'(n >= 47 && n <= 56), 16'h1);
    cycles(4);
    protMv <= 12'h12c;
    waitFor(1, 1'b1, 6, n);
    @(posedge sys_clk);
    protMv <= 12'h5dc;
    cycles(80);
    @(negedge sys_clk);
    chk("otRetest", 16'(faultActive), 16'h1);
    @(posedge sys_clk);
    protMv <= 12'ha28;
    waitFor(1, 1'b0, 60, n);
    @(posedge sys_clk);
    protMv <= 12'h5dc;
    $display("test overtemperature done");
    cycles(4);
    senseMv <= 12'h384;
    waitFor(0, 1'b0, 6, n);
    chk("sinkOn", 16'(brownoutHysteresisSinkEn), 16'h1);
    $display("test brown-out done");
    tally_and_finish();
  end
endmodule
